// file: core/liu_cfg_bank.sv
// transmit template and receive configuration register bank
//
// Overview of operation
// - a six-bit gain field, reset to 100001, scales user pulses by 3% a step.
// - writing one to control bit 7 starts the indirect template access.
// - control bit 6 chooses the access: zero writes the RAM, one reads it.
// - control bits 5-4 pick one of four unit intervals, zero the leftmost.
// - control bits 3-0 pick one of sixteen samples, zero the leftmost.
// - an indirect write loads data bits 6-0 into the addressed RAM word.
// - an indirect read returns the addressed RAM word in data bits 6-0.
// - receive config bit 4 set powers the receiver down.
// - receive config bit 3 set makes receive data active low.
// - receive bit 2 picks the falling edge, and slicer mode ignores it.
// - receive mode 00 gives HDB3-decoded single-rail NRZ data.
// - receive mode 01 gives AMI-decoded single-rail NRZ data.
// - receive mode 10 gives retimed dual-rail NRZ on both rails.
// - receive mode 11 bypasses recovery and decoder, raw RZ on both rails.
// - the transmitter uses the RAM waveform only for template choice 11XX.
`timescale 1ns/1ns
module liu_cfg_bank #(
    parameter int TMPL_DEPTH = liu_cfg_pkg::TMPL_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] tx_template_choice,
    input wire logic [5:0] tmpl_rd_addr,
    output logic [6:0] tmpl_sample,
    output logic tmpl_user_active,
    output logic [5:0] pulse_gain_step,
    output logic rx_power_down,
    output logic rx_polarity_flip,
    output logic rx_clk_falling,
    output logic [1:0] rx_decode_mode,
    output logic rx_single_rail,
    output logic rx_hdb3_decode,
    output logic rx_cdr_bypass,
    output logic [7:0] rx_config_secondary
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // register state
    logic [7:0] scaling_q, scaling_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] data_q, data_d;
    logic [7:0] rxpri_q, rxpri_d;
    logic [7:0] rxsec_q, rxsec_d;
    logic [7:0] rdata_d;

    // indirect access engine
    liu_cfg_pkg::acc_state_t state_q, state_d;
    logic [6:0] tmpl_ram [TMPL_DEPTH];
    logic [6:0] fetch_q;
    logic [5:0] ram_addr;
    logic ram_we;
    logic start;

    // receive side and template-use output flops
    logic rx_pd_d, rx_inv_d, rx_fall_d, rx_sr_d, rx_hdb3_d, rx_byp_d;
    logic tmpl_act_d;
    logic [1:0] mode;

    assign ram_addr = {ctrl_q[liu_cfg_pkg::POS_IVL +: liu_cfg_pkg::IVL_W],
        ctrl_q[liu_cfg_pkg::POS_POINT +: liu_cfg_pkg::POINT_W]};
    // a new trigger while busy is dropped, keeping the address stable
    assign start = reg_wr && hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_CTRL)
        && reg_wdata[liu_cfg_pkg::BIT_ACCESS_TRIGGER]
        && (state_q == liu_cfg_pkg::ST_IDLE);
    assign ram_we = (state_q == liu_cfg_pkg::ST_EXEC)
        && !ctrl_q[liu_cfg_pkg::BIT_ACCESS_DIR];
    assign mode = rxpri_q[liu_cfg_pkg::POS_RX_MODE +: 2];

    always_comb begin
        scaling_d = scaling_q;
        ctrl_d = ctrl_q;
        data_d = data_q;
        rxpri_d = rxpri_q;
        rxsec_d = rxsec_q;
        state_d = state_q;
        if (reg_wr) begin
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_PULSE_SCALING)) begin
                scaling_d = reg_wdata & liu_cfg_pkg::MASK_PULSE_SCALING;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_DATA)) begin
                data_d = reg_wdata & liu_cfg_pkg::MASK_TMPL_DATA;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_RX_CFG_PRI)) begin
                rxpri_d = reg_wdata & liu_cfg_pkg::MASK_RX_CFG_PRI;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_RX_CFG_SEC)) begin
                rxsec_d = reg_wdata & liu_cfg_pkg::MASK_RX_CFG_SEC;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_CTRL)
                && state_q == liu_cfg_pkg::ST_IDLE) begin
                ctrl_d = reg_wdata;
            end
        end
        case (state_q)
            liu_cfg_pkg::ST_IDLE: begin
                if (start) begin
                    state_d = liu_cfg_pkg::ST_EXEC;
                end
            end
            liu_cfg_pkg::ST_EXEC: begin
                if (ctrl_q[liu_cfg_pkg::BIT_ACCESS_DIR]) begin
                    state_d = liu_cfg_pkg::ST_FETCH;
                end else begin
                    state_d = liu_cfg_pkg::ST_IDLE;
                    ctrl_d[liu_cfg_pkg::BIT_ACCESS_TRIGGER] = 1'b0;
                end
            end
            liu_cfg_pkg::ST_FETCH: begin
                // engine result beats a host write to the data register
                data_d = {1'b0, fetch_q};
                state_d = liu_cfg_pkg::ST_IDLE;
                ctrl_d[liu_cfg_pkg::BIT_ACCESS_TRIGGER] = 1'b0;
            end
            default: begin
                state_d = liu_cfg_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb begin
        rdata_d = reg_rdata;
        if (reg_rd) begin
            rdata_d = 8'h00;
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_PULSE_SCALING)) begin
                rdata_d = scaling_q;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_CTRL)) begin
                rdata_d = ctrl_q;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_DATA)) begin
                rdata_d = data_q;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_RX_CFG_PRI)) begin
                rdata_d = rxpri_q;
            end
            if (hit(reg_addr, liu_cfg_pkg::OFS_RX_CFG_SEC)) begin
                rdata_d = rxsec_q;
            end
        end
    end

    always_comb begin
        rx_pd_d = rxpri_q[liu_cfg_pkg::BIT_RX_POWER_DOWN];
        rx_inv_d = rxpri_q[liu_cfg_pkg::BIT_RX_POLARITY];
        // slicer output is unretimed, so no edge choice applies
        rx_fall_d = rxpri_q[liu_cfg_pkg::BIT_RX_CLK_EDGE]
            && (mode != liu_cfg_pkg::MODE_SLICER);
        rx_sr_d = (mode == liu_cfg_pkg::MODE_HDB3)
            || (mode == liu_cfg_pkg::MODE_AMI);
        rx_hdb3_d = (mode == liu_cfg_pkg::MODE_HDB3);
        rx_byp_d = (mode == liu_cfg_pkg::MODE_SLICER);
        tmpl_act_d = (tx_template_choice[3:2]
            == liu_cfg_pkg::TMPL_USER_TOP);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            scaling_q <= liu_cfg_pkg::RST_TX_PULSE_SCALING;
            ctrl_q <= liu_cfg_pkg::RST_TX_TMPL_CTRL;
            data_q <= liu_cfg_pkg::RST_TX_TMPL_DATA;
            rxpri_q <= liu_cfg_pkg::RST_RX_CFG_PRI;
            rxsec_q <= liu_cfg_pkg::RST_RX_CFG_SEC;
            state_q <= liu_cfg_pkg::ST_IDLE;
            reg_rdata <= 8'h00;
        end else begin
            scaling_q <= scaling_d;
            ctrl_q <= ctrl_d;
            data_q <= data_d;
            rxpri_q <= rxpri_d;
            rxsec_q <= rxsec_d;
            state_q <= state_d;
            reg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_power_down <= 1'b0;
            rx_polarity_flip <= 1'b0;
            rx_clk_falling <= 1'b0;
            rx_decode_mode <= liu_cfg_pkg::MODE_HDB3;
            rx_single_rail <= 1'b1;
            rx_hdb3_decode <= 1'b1;
            rx_cdr_bypass <= 1'b0;
            rx_config_secondary <= liu_cfg_pkg::RST_RX_CFG_SEC;
            tmpl_user_active <= 1'b0;
            pulse_gain_step <= liu_cfg_pkg::RST_TX_PULSE_SCALING[5:0];
        end else begin
            rx_power_down <= rx_pd_d;
            rx_polarity_flip <= rx_inv_d;
            rx_clk_falling <= rx_fall_d;
            rx_decode_mode <= mode;
            rx_single_rail <= rx_sr_d;
            rx_hdb3_decode <= rx_hdb3_d;
            rx_cdr_bypass <= rx_byp_d;
            rx_config_secondary <= rxsec_q;
            tmpl_user_active <= tmpl_act_d;
            pulse_gain_step <= scaling_q[5:0];
        end
    end

    // template RAM has no reset; contents are undefined until loaded
    always_ff @(posedge clk_sys) begin
        if (ram_we) begin
            tmpl_ram[ram_addr] <= data_q[6:0];
        end
        fetch_q <= tmpl_ram[ram_addr];
        tmpl_sample <= tmpl_ram[tmpl_rd_addr];
    end

    // checks
    logic [6:0] word_at_addr;
    assign word_at_addr = tmpl_ram[ram_addr];

    chk_gain_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && hit(reg_addr, liu_cfg_pkg::OFS_TX_PULSE_SCALING)
        |-> ##2 pulse_gain_step == $past(reg_wdata[5:0], 2))
        else $error("gain step does not follow write");

    chk_trigger_start: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        start |=> state_q == liu_cfg_pkg::ST_EXEC
            && ctrl_q[liu_cfg_pkg::BIT_ACCESS_TRIGGER])
        else $error("trigger did not start access");

    chk_dir_select: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == liu_cfg_pkg::ST_EXEC
        |=> (state_q == liu_cfg_pkg::ST_FETCH)
            == $past(ctrl_q[liu_cfg_pkg::BIT_ACCESS_DIR]))
        else $error("access direction wrong");

    chk_ram_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ram_we |=> word_at_addr == $past(data_q[6:0]))
        else $error("template word not written");

    chk_read_back: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == liu_cfg_pkg::ST_EXEC
            && ctrl_q[liu_cfg_pkg::BIT_ACCESS_DIR]
        |-> ##2 data_q[6:0] == $past(word_at_addr, 2))
        else $error("read data not returned");

    chk_trigger_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        start |-> ##[2:3] !ctrl_q[liu_cfg_pkg::BIT_ACCESS_TRIGGER])
        else $error("trigger bit did not clear");

    chk_rx_power: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 rx_power_down == $past(rxpri_q[liu_cfg_pkg::BIT_RX_POWER_DOWN]))
        else $error("power down mismatch");

    chk_rx_polarity: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 rx_polarity_flip == $past(rxpri_q[liu_cfg_pkg::BIT_RX_POLARITY]))
        else $error("polarity mismatch");

    chk_edge_ignored: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode == liu_cfg_pkg::MODE_SLICER |=> !rx_clk_falling)
        else $error("edge select used in slicer mode");

    chk_mode_rails: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 rx_single_rail == !$past(mode[1])
            && rx_cdr_bypass == ($past(mode) == liu_cfg_pkg::MODE_SLICER))
        else $error("decode mode outputs wrong");

    chk_template_use: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 tmpl_user_active == (&$past(tx_template_choice[3:2])))
        else $error("template use mismatch");

    // index rebuilt from the control fields, so a swapped order shows
    chk_ram_index: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ram_we |=> tmpl_ram[{$past(ctrl_q[liu_cfg_pkg::POS_IVL +: 2]),
            $past(ctrl_q[liu_cfg_pkg::POS_POINT +: 4])}]
            == $past(data_q[6:0]))
        else $error("template word landed at wrong index");

    chk_data_write: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_DATA)
            && state_q != liu_cfg_pkg::ST_FETCH
        |=> data_q == $past(reg_wdata & liu_cfg_pkg::MASK_TMPL_DATA))
        else $error("template data write lost");

    chk_busy_ignore: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && hit(reg_addr, liu_cfg_pkg::OFS_TX_TMPL_CTRL)
            && state_q != liu_cfg_pkg::ST_IDLE
        |=> $stable(ctrl_q[6:0]) && state_q != liu_cfg_pkg::ST_EXEC)
        else $error("busy write disturbed the access");

    chk_write_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == liu_cfg_pkg::ST_EXEC
            && !ctrl_q[liu_cfg_pkg::BIT_ACCESS_DIR]
        |=> state_q == liu_cfg_pkg::ST_IDLE
            && !ctrl_q[liu_cfg_pkg::BIT_ACCESS_TRIGGER])
        else $error("write access did not finish");

    chk_fetch_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state_q == liu_cfg_pkg::ST_FETCH
        |=> state_q == liu_cfg_pkg::ST_IDLE
            && !ctrl_q[liu_cfg_pkg::BIT_ACCESS_TRIGGER]
            && data_q == {1'b0, $past(fetch_q)})
        else $error("read access did not finish");

    chk_gain_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !(reg_wr && hit(reg_addr, liu_cfg_pkg::OFS_TX_PULSE_SCALING))
        |=> $stable(scaling_q))
        else $error("gain field changed without a write");

    chk_edge_follow: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        mode != liu_cfg_pkg::MODE_SLICER
        |=> rx_clk_falling == $past(rxpri_q[liu_cfg_pkg::BIT_RX_CLK_EDGE]))
        else $error("edge select not followed");

    chk_hdb3_select: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 rx_hdb3_decode == ($past(mode) == liu_cfg_pkg::MODE_HDB3)
            && rx_decode_mode == $past(mode))
        else $error("decoder select wrong");

    chk_rx_readback: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        reg_rd && hit(reg_addr, liu_cfg_pkg::OFS_RX_CFG_PRI)
        |=> reg_rdata == $past(rxpri_q))
        else $error("receive config read wrong");

endmodule

// file: core/liu_cfg_pkg.sv
// constants and types for the line interface config bank
package liu_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int AMP_W = 7;
    localparam int IVL_W = 2;
    localparam int POINT_W = 4;
    localparam int TMPL_AW = IVL_W + POINT_W;
    localparam int TMPL_DEPTH = 64;

    localparam logic [7:0] OFS_TX_PULSE_SCALING = 8'h07;
    localparam logic [7:0] OFS_TX_TMPL_CTRL = 8'h08;
    localparam logic [7:0] OFS_TX_TMPL_DATA = 8'h09;
    localparam logic [7:0] OFS_RX_CFG_PRI = 8'h0A;
    localparam logic [7:0] OFS_RX_CFG_SEC = 8'h0B;

    localparam logic [7:0] RST_TX_PULSE_SCALING = 8'h21;
    localparam logic [7:0] RST_TX_TMPL_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_TMPL_DATA = 8'h00;
    localparam logic [7:0] RST_RX_CFG_PRI = 8'h00;
    localparam logic [7:0] RST_RX_CFG_SEC = 8'h15;

    localparam logic [7:0] MASK_PULSE_SCALING = 8'h3F;
    localparam logic [7:0] MASK_TMPL_DATA = 8'h7F;
    localparam logic [7:0] MASK_RX_CFG_PRI = 8'h1F;
    localparam logic [7:0] MASK_RX_CFG_SEC = 8'h5F;

    localparam int BIT_ACCESS_TRIGGER = 7;
    localparam int BIT_ACCESS_DIR = 6;
    localparam int POS_IVL = 4;
    localparam int POS_POINT = 0;
    localparam int BIT_RX_POWER_DOWN = 4;
    localparam int BIT_RX_POLARITY = 3;
    localparam int BIT_RX_CLK_EDGE = 2;
    localparam int POS_RX_MODE = 0;

    localparam logic [1:0] MODE_HDB3 = 2'h0;
    localparam logic [1:0] MODE_AMI = 2'h1;
    localparam logic [1:0] MODE_RETIMED = 2'h2;
    localparam logic [1:0] MODE_SLICER = 2'h3;
    localparam logic [1:0] TMPL_USER_TOP = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FETCH = 3'b100
    } acc_state_t;
endpackage

// file: tb/host_model.sv
// host model driving the register strobe port
`timescale 1ns/1ns
module host_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // released bus shows junk so stale values cannot pass
        reg_wdata <= ~d;
        reg_addr <= ~a;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    // start an indirect access, then poll until the trigger drops
    task automatic access(input logic [7:0] c, output int polls);
        logic [7:0] v;
        wr(8'h08, c);
        polls = 0;
        v = 8'h80;
        while (v[7] && polls < 8) begin
            rd(8'h08, v);
            polls++;
        end
    endtask
endmodule

// file: tb/tb_liu_cfg_bank.sv
// testbench for the line interface config bank
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb_liu_cfg_bank;
    logic clk_sys, rst_b, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_config_secondary, v, wd;
    logic [3:0] tx_template_choice;
    logic [5:0] tmpl_rd_addr, pulse_gain_step;
    logic [6:0] tmpl_sample, w;
    logic tmpl_user_active, rx_power_down, rx_polarity_flip, rx_clk_falling;
    logic rx_single_rail, rx_hdb3_decode, rx_cdr_bypass;
    logic [1:0] rx_decode_mode, m;
    logic [2:0] b;
    int err_total = 0, check_count = 0, cyc = 0, polls;
    logic [7:0] rst_tab [6] = '{8'h21, 8'h00, 8'h00, 8'h00, 8'h15, 8'h00};
    logic [7:0] msk_tab [6] = '{8'h3F, 8'h00, 8'h7F, 8'h1F, 8'h5F, 8'h00};
    // addresses 1C and 23 not symmetric, so a swapped field order is caught
    logic [5:0] ta [4] = '{6'h00, 6'h1C, 6'h23, 6'h3F};
    liu_cfg_bank dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_template_choice(tx_template_choice),
        .tmpl_rd_addr(tmpl_rd_addr), .tmpl_sample(tmpl_sample),
        .tmpl_user_active(tmpl_user_active),
        .pulse_gain_step(pulse_gain_step), .rx_power_down(rx_power_down),
        .rx_polarity_flip(rx_polarity_flip),
        .rx_clk_falling(rx_clk_falling), .rx_decode_mode(rx_decode_mode),
        .rx_single_rail(rx_single_rail), .rx_hdb3_decode(rx_hdb3_decode),
        .rx_cdr_bypass(rx_cdr_bypass),
        .rx_config_secondary(rx_config_secondary));
    host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // whole run needs about 240 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        rst_b = 1'b0;
        tx_template_choice = 4'h0;
        tmpl_rd_addr = 6'h00;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        `CHK("gain_rst", 6'h21, pulse_gain_step)
        `CHK("hdb3_rst", 1'b1, rx_hdb3_decode)
        `CHK("sec_rst", 8'h15, rx_config_secondary)
        for (int i = 0; i < 6; i++) begin
            host.rd(8'h07 + 8'(i), v);
            `CHK("reg_rst", rst_tab[i], v)
        end
        for (int i = 0; i < 6; i++) begin
            if (i != 1) host.wr(8'h07 + 8'(i), 8'hFF);
        end
        for (int i = 0; i < 6; i++) begin
            if (i != 1) host.rd(8'h07 + 8'(i), v);
            if (i != 1) `CHK("reserved", msk_tab[i], v)
        end
        settle();
        `CHK("gain_out", 6'h3F, pulse_gain_step)
        `CHK("sec_out", 8'h5F, rx_config_secondary)
        $display("test reset and reserved done");
        for (int i = 0; i < 8; i++) begin
            b = 3'(i);
            m = b[1:0];
            wd = {3'b000, b[0], b[1], b[2], m};
            host.wr(8'h0A, wd);
            host.rd(8'h0A, v);
            `CHK("rx_cfg", wd, v)
            `CHK("pdown", b[0], rx_power_down)
            `CHK("polar", b[1], rx_polarity_flip)
            `CHK("edge", b[2] && m != 2'h3, rx_clk_falling)
            `CHK("mode", m, rx_decode_mode)
            `CHK("single", m < 2'h2, rx_single_rail)
            `CHK("hdb3", m == 2'h0, rx_hdb3_decode)
            `CHK("bypass", m == 2'h3, rx_cdr_bypass)
        end
        $display("test receive modes done");
        for (int i = 0; i < 4; i++) begin
            w = 7'(ta[i]) ^ 7'h55;
            host.wr(8'h09, {1'b1, w});
            host.access({2'b10, ta[i]}, polls);
            `CHK("wr_done", 1'b1, polls == 1)
            @(posedge clk_sys);
            tmpl_rd_addr <= ta[i];
            settle();
            `CHK("ram_word", w, tmpl_sample)
            host.wr(8'h09, 8'h00);
            host.access({2'b11, ta[i]}, polls);
            `CHK("rd_done", 1'b1, polls <= 2)
            host.rd(8'h09, v);
            `CHK("rd_word", {1'b0, w}, v)
        end
        // second trigger lands while the read is still busy
        host.wr(8'h08, 8'hDC);
        host.wr(8'h08, 8'hA3);
        host.rd(8'h08, v);
        `CHK("trig_clr", 1'b0, v[7])
        host.rd(8'h09, v);
        `CHK("busy_rd", 8'h49, v)
        @(posedge clk_sys);
        tmpl_rd_addr <= 6'h23;
        settle();
        `CHK("busy_keep", 7'h76, tmpl_sample)
        $display("test template access done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            tx_template_choice <= 4'(i);
            settle();
            `CHK("user_tmpl", i >= 12, tmpl_user_active)
        end
        $display("test template choice done");
        conclude();
    end
endmodule
